/* hw/sso_pkg.sv */
// Purpose: shared constants and types for the servo status output block
// Assumes: one 250 MHz clock, restart-only settings sampled once after reset release
// Notes: contact level 1 means closed
package sso_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned ERR_PULSE_S = 2;
  localparam longint unsigned ERR_PULSE_CYC_DEF = longint'(ERR_PULSE_S) * CLK_HZ;
  localparam int unsigned WIDTH_W = 17;
  localparam logic [16:0] WIDTH_MAX = 17'h1869F;
  localparam logic [16:0] WIDTH_RST = 17'h00001;
  localparam int unsigned ERR_W = 32;
  localparam int unsigned DELAY_W = 32;
  localparam int unsigned CODE_W = 3;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [1:0] CLR_RISE = 2'h0;
  localparam logic [1:0] CLR_FALL = 2'h1;
  localparam logic [31:0] CNT_ZERO = 32'h00000000;
  localparam logic [31:0] CNT_ONE = 32'h00000001;

  typedef enum logic [1:0] {
    SSO_BRK_HELD,
    SSO_BRK_RELEASED,
    SSO_BRK_DELAY
  } sso_brake_state_t;

  typedef struct packed {
    logic code_output_select;
    logic [1:0] fault_clear_mode;
    logic brake_polarity;
    logic ready_polarity;
    logic caution_polarity;
    logic target_reached_polarity;
  } sso_cfg_t;
endpackage : sso_pkg

/* hw/sso_cfg_if.sv */
// Purpose: carries latched settings between the status block's modules
// Assumes: driven by the setting latch only
// Notes: valid is low until the first sample after reset
`timescale 1ns/100ps
interface sso_cfg_if;
  import sso_pkg::*;
  sso_cfg_t cfg;
  logic valid;
  modport source (output cfg, output valid);
  modport sink (input cfg, input valid);
endinterface : sso_cfg_if

/* hw/sso_cfg_latch.sv */
// Purpose: samples the restart-only settings once after reset release
// Assumes: setting pins are stable around reset release
// Notes: later pin changes are ignored until the next reset
`timescale 1ns/100ps
module sso_cfg_latch
  import sso_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // raw settings
  input wire sso_cfg_t cfg_in,
  // latched settings
  sso_cfg_if.source cfg_bus
);
  typedef struct packed {
    sso_cfg_t cfg;
    logic valid;
  } sso_latch_st_t;

  sso_latch_st_t st_ff;
  sso_latch_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.valid) begin
      nxt_st.cfg = cfg_in;
      nxt_st.valid = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg_bus.cfg = st_ff.cfg;
  assign cfg_bus.valid = st_ff.valid;
endmodule : sso_cfg_latch

/* hw/sso_pulse_stretch.sv */
// Purpose: stretches a one-cycle error event to a fixed-length pulse
// Assumes: length is at least one cycle
// Notes: a new event restarts the full length
`timescale 1ns/100ps
module sso_pulse_stretch
  import sso_pkg::*;
#(
  parameter logic [31:0] LEN = 32'(ERR_PULSE_CYC_DEF)
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // event and stretched level
  input wire logic event_in,
  output logic pulse_out
);
  typedef struct packed {
    logic [31:0] cnt;
  } sso_stretch_st_t;

  sso_stretch_st_t st_ff;
  sso_stretch_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (event_in) begin
      nxt_st.cnt = LEN;
    end else if (st_ff.cnt != CNT_ZERO) begin
      nxt_st.cnt = st_ff.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_out = (st_ff.cnt != CNT_ZERO);
endmodule : sso_pulse_stretch

/* hw/sso_status_outputs.sv */
// Purpose: servo drive status outputs: fault, code, brake, ready, caution, in-position
// Assumes: fault detection, position error and motor state come from the drive core
// Notes: contact level 1 = closed; all outputs registered
`timescale 1ns/100ps

// Summary of operation
// - fault contact closed when normal, open while any fault is latched.
// - with code output on, three lines carry the latched fault type code.
// - select 0 routes caution, brake, ready; 1 routes fault code lines.
// - clear mode 0 clears on close, 1 on open, 2 and 3 ignore.
// - encoder faults are not cleared by the clear input.
// - brake applied whenever a fault is present or motor power is off.
// - brake polarity 0 closes to release, 1 opens to release.
// - brake apply instant delayed by a programmable cycle count.
// - ready only with main power on, no base-block and no fault.
// - ready polarity 0 closes when ready, 1 opens when ready.
// - an error event drives caution for exactly two seconds.
// - a warning holds caution until its condition clears.
// - caution polarity 0 closes on caution, 1 opens on caution.
// - in-position when position error magnitude is below the window width.
// - in-position also whenever the motor is stopped.
// - in-position polarity 0 closes on completion, 1 opens.
// - window width 0 to 99999, default 1, used live.
module sso_status_outputs
  import sso_pkg::*;
#(
  parameter logic [31:0] ERR_PULSE_CYC = 32'(ERR_PULSE_CYC_DEF)
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // restart-only settings
  input wire logic code_output_select,
  input wire logic [1:0] fault_clear_mode,
  input wire logic brake_polarity,
  input wire logic ready_polarity,
  input wire logic caution_polarity,
  input wire logic target_reached_polarity,
  // live settings
  input wire logic [16:0] target_window_width,
  input wire logic [31:0] brake_release_delay,
  // drive status
  input wire logic fault_detect,
  input wire logic [2:0] fault_detect_code,
  input wire logic fault_is_encoder,
  input wire logic main_power_on,
  input wire logic motor_power_on,
  input wire logic base_block,
  input wire logic error_event,
  input wire logic warning_active,
  input wire logic motor_stopped,
  input wire logic [31:0] position_error,
  // fault clear contact, 1 = closed
  input wire logic fault_clear_in,
  // output contacts, 1 = closed
  output logic servo_fault_out,
  output logic fault_code_bit1,
  output logic fault_code_bit2,
  output logic fault_code_bit3,
  output logic caution_out,
  output logic brake_release_out,
  output logic servo_ready_out,
  output logic target_reached_out,
  // status
  output logic fault_latched
);
  typedef struct packed {
    logic fault;
    logic encoder;
    logic [2:0] code;
    logic clr_prev;
    sso_brake_state_t brk;
    logic [31:0] brk_cnt;
    logic pin_fault;
    logic [2:0] pin_shared;
    logic pin_target;
  } sso_top_st_t;

  sso_top_st_t st_ff;
  sso_top_st_t nxt_st;

  sso_cfg_if cfg_bus ();
  sso_cfg_t cfg_raw;
  logic err_pulse;

  assign cfg_raw = '{code_output_select: code_output_select,
                     fault_clear_mode: fault_clear_mode,
                     brake_polarity: brake_polarity,
                     ready_polarity: ready_polarity,
                     caution_polarity: caution_polarity,
                     target_reached_polarity: target_reached_polarity};

  sso_cfg_latch u_cfg (
    .clock(clock),
    .reset_n(reset_n),
    .cfg_in(cfg_raw),
    .cfg_bus(cfg_bus.source)
  );

  sso_pulse_stretch #(.LEN(ERR_PULSE_CYC)) u_err (
    .clock(clock),
    .reset_n(reset_n),
    .event_in(error_event),
    .pulse_out(err_pulse)
  );

  sso_cfg_t cfg;
  logic clr_edge;
  logic clr_now;
  logic brake_want;
  logic ready_act;
  logic caution_act;
  logic target_act;
  logic [31:0] err_mag;
  logic [16:0] width_eff;

  assign cfg = cfg_bus.cfg;

  always_comb begin
    clr_now = fault_clear_in;
    clr_edge = 1'b0;
    case (cfg.fault_clear_mode)
      CLR_RISE: clr_edge = clr_now && !st_ff.clr_prev;
      CLR_FALL: clr_edge = !clr_now && st_ff.clr_prev;
      default: clr_edge = 1'b0;
    endcase
    width_eff = (target_window_width > WIDTH_MAX) ? WIDTH_MAX : target_window_width;
    err_mag = position_error[31] ? (~position_error + CNT_ONE) : position_error;
    target_act = (err_mag < {15'h0000, width_eff});
    target_act = target_act || motor_stopped;
    caution_act = err_pulse || warning_active;
    ready_act = main_power_on && !base_block && !st_ff.fault && !fault_detect;
    brake_want = motor_power_on && !st_ff.fault && !fault_detect;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clr_prev = fault_clear_in;
    // encoder faults stick; detection wins over clear
    if (clr_edge && !st_ff.encoder && cfg_bus.valid) begin
      nxt_st.fault = 1'b0;
      nxt_st.code = CODE_NONE;
    end
    if (fault_detect) begin
      nxt_st.fault = 1'b1;
      nxt_st.code = fault_detect_code;
      nxt_st.encoder = st_ff.encoder || fault_is_encoder;
    end
    case (st_ff.brk)
      SSO_BRK_HELD: begin
        if (brake_want) begin
          nxt_st.brk = SSO_BRK_RELEASED;
        end
      end
      SSO_BRK_RELEASED: begin
        if (!brake_want) begin
          nxt_st.brk_cnt = brake_release_delay;
          nxt_st.brk = (brake_release_delay == CNT_ZERO) ? SSO_BRK_HELD : SSO_BRK_DELAY;
        end
      end
      SSO_BRK_DELAY: begin
        if (brake_want) begin
          nxt_st.brk = SSO_BRK_RELEASED;
        end else if (st_ff.brk_cnt <= CNT_ONE) begin
          nxt_st.brk = SSO_BRK_HELD;
        end else begin
          nxt_st.brk_cnt = st_ff.brk_cnt - CNT_ONE;
        end
      end
      default: nxt_st.brk = SSO_BRK_HELD;
    endcase
    nxt_st.pin_fault = !nxt_st.fault;
    if (cfg.code_output_select) begin
      nxt_st.pin_shared = nxt_st.code;
    end else begin
      nxt_st.pin_shared[0] = caution_act ^ cfg.caution_polarity;
      nxt_st.pin_shared[1] = (nxt_st.brk != SSO_BRK_HELD) ^ cfg.brake_polarity;
      nxt_st.pin_shared[2] = ready_act ^ cfg.ready_polarity;
    end
    nxt_st.pin_target = target_act ^ cfg.target_reached_polarity;
    // output contacts stay open (level 0) until settings are sampled
    if (!cfg_bus.valid) begin
      nxt_st.pin_shared = '0;
      nxt_st.pin_target = 1'b0;
      nxt_st.pin_fault = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{fault: 1'b0, encoder: 1'b0, code: CODE_NONE, clr_prev: 1'b0,
                 brk: SSO_BRK_HELD, brk_cnt: CNT_ZERO, pin_fault: 1'b0,
                 pin_shared: 3'h0, pin_target: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign servo_fault_out = st_ff.pin_fault;
  assign fault_code_bit1 = st_ff.pin_shared[0];
  assign fault_code_bit2 = st_ff.pin_shared[1];
  assign fault_code_bit3 = st_ff.pin_shared[2];
  assign caution_out = st_ff.pin_shared[0];
  assign brake_release_out = st_ff.pin_shared[1];
  assign servo_ready_out = st_ff.pin_shared[2];
  assign target_reached_out = st_ff.pin_target;
  assign fault_latched = st_ff.fault;
endmodule : sso_status_outputs

/* tb/sso_host_model.sv */
// Purpose: host side that works the fault clear contact
// Assumes: press is a one-cycle request from the bench
// Notes: contact leaves its idle level for four cycles per press
`timescale 1ns/100ps
module sso_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // request and idle level of the contact
  input wire logic press,
  input wire logic idle_closed,
  // contact, 1 = closed
  output logic fault_clear_in
);
  logic [2:0] hold_ff;
  // one full open/close swing per press
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) hold_ff <= 3'h0;
    else if (press) hold_ff <= 3'h4;
    else if (hold_ff != 3'h0) hold_ff <= hold_ff - 3'h1;
  end
  assign fault_clear_in = idle_closed ^ (hold_ff != 3'h0);
endmodule : sso_host_model

/* tb/sso_sva.sv */
// Purpose: port checker for the status outputs
// Assumes: restart-only settings change only while reset is low
// Notes: checks start two cycles after reset release
`timescale 1ns/100ps
module sso_sva
  import sso_pkg::*;
(
  // clock and reset
  input wire logic clock, reset_n,
  // settings
  input wire logic code_output_select, ready_polarity, brake_polarity,
  input wire logic caution_polarity, target_reached_polarity,
  input wire logic [1:0] fault_clear_mode,
  input wire logic [16:0] target_window_width,
  input wire logic [31:0] brake_release_delay, position_error,
  // drive status
  input wire logic fault_detect, main_power_on, motor_power_on, base_block,
  input wire logic error_event, warning_active, motor_stopped,
  input wire logic [2:0] fault_detect_code,
  // pins
  input wire logic servo_fault_out, fault_code_bit1, fault_code_bit2, fault_code_bit3,
  input wire logic caution_out, brake_release_out, servo_ready_out,
  input wire logic target_reached_out, fault_latched
);
  logic [1:0] up_ff;
  logic [31:0] mag;
  logic far;
  assign mag = position_error[31] ? -position_error : position_error;
  assign far = !motor_stopped && mag >= 32'(target_window_width);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) up_ff <= 2'h0;
    else if (!up_ff[1]) up_ff <= up_ff + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n || !up_ff[1]);
  sequence s_err;
    error_event && !warning_active && !code_output_select;
  endsequence
  sequence s_cau_on;
    (caution_out != caution_polarity)[*8];
  endsequence
  a_fault_open: assert property (fault_detect |=> !servo_fault_out && fault_latched)
    else $error("fault contact not open");
  a_ready_drop: assert property (!code_output_select && fault_detect
    |=> servo_ready_out == ready_polarity) else $error("ready kept on fault");
  a_ready_on: assert property (((!code_output_select && main_power_on && !base_block
    && !fault_latched && !fault_detect)[*2]) |=> servo_ready_out != ready_polarity)
    else $error("ready missing");
  a_brake_apply: assert property (((!code_output_select && !motor_power_on
    && brake_release_delay == 32'h0)[*3]) |-> brake_release_out == brake_polarity)
    else $error("brake not applied");
  a_caution_len: assert property (s_err |-> ##2 s_cau_on) else $error("error pulse short");
  a_caution_warn: assert property (!code_output_select && warning_active
    |=> caution_out != caution_polarity) else $error("warning not shown");
  a_inpos_stop: assert property (motor_stopped
    |=> target_reached_out != target_reached_polarity) else $error("stop not in position");
  a_inpos_far: assert property (far |=> target_reached_out == target_reached_polarity)
    else $error("in position while far");
  a_clear_ignored: assert property (fault_clear_mode[1] && fault_latched |=> fault_latched)
    else $error("fault cleared in ignore mode");
  a_code_bits: assert property (code_output_select && fault_detect ##1 !fault_detect
    |=> {fault_code_bit3, fault_code_bit2, fault_code_bit1} == $past(fault_detect_code, 2))
    else $error("fault code wrong");
endmodule : sso_sva
bind sso_status_outputs sso_sva chk (.*);

/* tb/tb_top.sv */
// Purpose: self-checking bench for the status outputs
// Assumes: error pulse shortened to 20 cycles
// Notes: restart-only settings only change as reset goes low
`timescale 1ns/100ps
module tb_top;
  import sso_pkg::*;
  typedef struct { logic [3:0] f; logic [31:0] pe; logic [16:0] w; logic [2:0] e; } sso_row_t;
  logic clock, reset_n, code_output_select, brake_polarity, ready_polarity;
  logic caution_polarity, target_reached_polarity, fault_detect, fault_is_encoder;
  logic main_power_on, motor_power_on, base_block, error_event, warning_active;
  logic motor_stopped, fault_clear_in, press, idle_closed;
  logic [1:0] fault_clear_mode;
  logic [2:0] fault_detect_code;
  logic [16:0] target_window_width;
  logic [31:0] brake_release_delay, position_error;
  logic servo_fault_out, fault_code_bit1, fault_code_bit2, fault_code_bit3;
  logic caution_out, brake_release_out, servo_ready_out, target_reached_out, fault_latched;
  int failures, compares, cycles, n;
  // flags: main power, base-block, warning, stopped; expect ready, caution, in-position
  // last row: a width above the range is clamped, so an error of the maximum is not in position
  sso_row_t rows[7] = '{'{4'h8, 32'h0, 17'h1, 3'h5}, '{4'h0, 32'h1, 17'h1, 3'h0},
    '{4'hE, 32'hFFFFFFFB, 17'h6, 3'h3}, '{4'h9, 32'h186A0, 17'h1869F, 3'h5},
    '{4'h8, 32'h1869E, 17'h1869F, 3'h5}, '{4'h8, 32'h0, 17'h0, 3'h4},
    '{4'h8, 32'h1869F, 17'h1FFFF, 3'h4}};

  sso_status_outputs #(.ERR_PULSE_CYC(32'h14)) uut (.*);
  sso_host_model host (.*);

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic restart();
    reset_n = 1'b0;
    cyc(4);
    check({servo_fault_out, servo_ready_out, target_reached_out}, 3'h0);
    reset_n = 1'b1;
    cyc(3);
  endtask : restart
  task automatic fault(input logic [2:0] c, input logic enc);
    fault_detect = 1'b1;
    fault_detect_code = c;
    fault_is_encoder = enc;
    cyc(1);
    fault_detect = 1'b0;
    fault_is_encoder = 1'b0;
    cyc(1);
  endtask : fault
  task automatic clr();
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    cyc(8);
  endtask : clr
  task automatic wrap_up();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    {code_output_select, brake_polarity, ready_polarity, caution_polarity} = 4'h0;
    {target_reached_polarity, fault_detect, fault_is_encoder, base_block} = 4'h0;
    {error_event, warning_active, motor_stopped, press, idle_closed} = 5'h0;
    {main_power_on, motor_power_on} = 2'h3;
    fault_clear_mode = 2'h0;
    fault_detect_code = 3'h0;
    target_window_width = 17'h1;
    brake_release_delay = 32'h0;
    position_error = 32'h0;
    restart();
    foreach (rows[i]) begin
      {main_power_on, base_block, warning_active, motor_stopped} = rows[i].f;
      position_error = rows[i].pe;
      target_window_width = rows[i].w;
      cyc(2);
      check({servo_ready_out, caution_out, target_reached_out}, rows[i].e);
    end
    {main_power_on, base_block, warning_active, motor_stopped} = 4'h8;
    target_window_width = 17'h1;
    position_error = 32'h0;
    fault(3'h5, 1'b0);
    check({servo_fault_out, servo_ready_out, brake_release_out}, 3'h0);
    clr();
    check(servo_fault_out, 1'b1);
    fault(3'h1, 1'b1);
    clr();
    check(fault_latched, 1'b1);
    restart();
    error_event = 1'b1;
    cyc(1);
    error_event = 1'b0;
    n = 0;
    repeat (40) begin
      cyc(1);
      if (caution_out === 1'b1) n++;
    end
    check(n, 20);
    brake_release_delay = 32'h5;
    motor_power_on = 1'b0;
    n = 0;
    while (brake_release_out === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n >= 5 && n <= 7, 1'b1);
    motor_power_on = 1'b1;
    brake_release_delay = 32'h0;
    cyc(2);
    check(brake_release_out, 1'b1);
    {code_output_select, target_reached_polarity, idle_closed} = 3'h7;
    fault_clear_mode = 2'h1;
    restart();
    check(target_reached_out, 1'b0);
    fault(3'h6, 1'b0);
    check({fault_code_bit3, fault_code_bit2, fault_code_bit1}, 3'h6);
    check({servo_ready_out, brake_release_out, caution_out}, 3'h6);
    clr();
    check({servo_fault_out, fault_code_bit3, fault_code_bit2, fault_code_bit1}, 4'h8);
    {code_output_select, target_reached_polarity, idle_closed} = 3'h0;
    {brake_polarity, ready_polarity, caution_polarity} = 3'h7;
    for (int m = 2; m < 4; m++) begin
      fault_clear_mode = 2'(m);
      restart();
      check(brake_release_out, 1'b0);
      fault(3'h2, 1'b0);
      check({servo_ready_out, brake_release_out, caution_out}, 3'h7);
      clr();
      check(fault_latched, 1'b1);
    end
    wrap_up();
  end
endmodule : tb_top
